// ==== design/ppf_pkg.sv ====
// Register map, reset values and field positions of the port pin function block
package ppf_pkg;
  // Printed offsets are not all multiples of four: each is a word index
  localparam logic [31:0] ANALOG_PORT_LATCH_LOW_IDX       = 32'hfffff40e;
  localparam logic [31:0] ANALOG_PORT_LATCH_HIGH_IDX      = 32'hfffff40f;
  localparam logic [31:0] ANALOG_PORT_DIRECTION_LOW_IDX   = 32'hfffff42e;
  localparam logic [31:0] ANALOG_PORT_DIRECTION_HIGH_IDX  = 32'hfffff42f;
  localparam logic [31:0] TIMER_PIN_FUNCTION_SEL_HIGH_IDX = 32'hfffff46d;
  localparam logic [31:0] PIN_ALTERNATE_MODE_IDX          = 32'hfffff44c;
  localparam logic [31:0] PIN_ALTERNATE_MODE_UPPER_IDX    = 32'hfffff44d;
  localparam logic [31:0] PIN_OUTPUT_TYPE_IDX             = 32'hfffffc6c;
  localparam logic [31:0] PIN_OUTPUT_TYPE_UPPER_IDX       = 32'hfffffc6d;
  localparam logic [31:0] TWO_PIN_LATCH_IDX               = 32'hfffff410;
  localparam logic [31:0] TWO_PIN_DIRECTION_IDX           = 32'hfffff430;

  // Reset values
  localparam logic [15:0] PIN_ALTERNATE_MODE_RST = 16'h0000;
  localparam logic [15:0] PIN_OUTPUT_TYPE_RST    = 16'h0000;
  localparam logic [7:0]  TIMER_FUNC_SEL_RST     = 8'h00;
  localparam logic [7:0]  ANALOG_LATCH_RST       = 8'h00;
  localparam logic [7:0]  ANALOG_DIRECTION_RST   = 8'hff;
  localparam logic [1:0]  TWO_PIN_LATCH_RST      = 2'h0;
  localparam logic [1:0]  TWO_PIN_DIRECTION_RST  = 2'h3;

  // Writable bits; pins fourteen and fifteen have no alternate function
  localparam logic [15:0] PIN_ALTERNATE_MODE_MASK = 16'h3fff;
  localparam logic [7:0]  TIMER_FUNC_SEL_MASK     = 8'h32;

  // Pin positions on the first port
  localparam int RT_PIN_LAST       = 5;
  localparam int SERIAL_IN_BIT     = 6;
  localparam int SERIAL_OUT_BIT    = 7;
  localparam int SERIAL_CLOCK_BIT  = 8;
  localparam int TIMER_B0_BIT      = 9;
  localparam int TIMER_B1_IN_BIT   = 10;
  localparam int TIMER_B1_OUT_BIT  = 11;
  localparam int TIMER_C0_BIT      = 12;
  localparam int TIMER_C1_BIT      = 13;
  // Field positions inside the timer function select high byte
  localparam int FSEL_B0_POS = 1;
  localparam int FSEL_C0_POS = 4;
  localparam int FSEL_C1_POS = 5;
endpackage

// ==== design/ppf_port_pin_function.sv ====
// Port pin function select, output type and analog-shared port registers with APB access
`timescale 1ns/100ps
`default_nettype none

// Operation
// R1 - Pin ten mode bit: clear gives general I/O, set gives capture input.
// R2 - Pin nine mode bit: clear gives general I/O, set gives timer capture/output.
// R3 - Pins six to eight mode bits connect serial data in, out and clock.
// R4 - Mode register takes whole 16-bit access plus separate upper and lower bytes.
// R5 - Bits 8 to 15 appear as bits 0 to 7 of the upper-byte register.
// R6 - Pin thirteen select bit: 0 capture input, 1 timer output.
// R7 - Pin twelve select bit: 0 capture input, 1 timer output.
// R8 - Output type bit: 0 push-pull, 1 open-drain, sixteen bits.
// R9 - Software sets open-drain when the pin is pulled up externally.
// R10 - Output type register takes 16-bit access plus separate byte halves.
// R11 - Analog port latch bits drive pins in output mode, reset zero.
// R12 - Software avoids latch access during an analog conversion.
// R13 - Analog port registers refuse 16-bit access, allow byte access only.
// R14 - Analog port direction bit: 0 output, 1 input, reset all ones.
// R15 - Software sets direction to input before analog channel use.
// R16 - Two-pin port with per-pin direction control.
// R17 - In alternate mode the peripheral path controls the pin.
module ppf_port_pin_function (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] gpioLatch6,
  input  wire logic [15:0] gpioDir6,
  input  wire logic [15:0] pinIn6,
  output logic      [15:0] pinOut6,
  output logic      [15:0] pinOe6,
  input  wire logic [5:0]  realtimeOutputPin,
  input  wire logic        serialDataOutPin,
  input  wire logic        serialClockOut,
  input  wire logic        serialClockOe,
  output logic             serialDataInPin,
  output logic             serialClockIn,
  input  wire logic        timerOutputB0,
  input  wire logic        timerOutputB1,
  input  wire logic        timerOutputC0,
  input  wire logic        timerOutputC1,
  output logic             timerCaptureInputB0,
  output logic             timerCaptureInputB1,
  output logic             timerCaptureInputC0,
  output logic             timerCaptureInputC1,
  input  wire logic [15:0] analogPortPinIn,
  output logic      [15:0] analogPortPinOut,
  output logic      [15:0] analogPortPinOe,
  output logic      [15:0] analogInputChannel,
  input  wire logic [1:0]  twoPinIn,
  output logic      [1:0]  twoPinOut,
  output logic      [1:0]  twoPinOe
);

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
    hit = (addr == {idx[29:0], 2'h0});
  endfunction

  // Byte lane merge of a write into an 8-bit field
  function automatic logic [7:0] laneMerge(input logic [7:0] old, input logic [7:0] data, input logic en);
    laneMerge = en ? data : old;
  endfunction

  logic [15:0] pinAltMode_q;
  logic [15:0] pinOutType_q;
  logic [7:0]  timerFuncSel_q;
  logic [15:0] analogLatch_q;
  logic [15:0] analogDir_q;
  logic [1:0]  twoPinLatch_q;
  logic [1:0]  twoPinDir_q;
  logic [31:0] prdata_q;
  logic [31:0] rdData_d;
  logic        pready_q;
  logic        pslverr_q;
  logic        mapped_d;
  logic        refuse_d;
  logic        wrEn;
  logic        byteOnly;
  logic [15:0] altOut;
  logic [15:0] altDrive;
  logic [15:0] srcOut;
  logic [15:0] srcDrive;
  logic [15:0] pinOut6_q;
  logic [15:0] pinOe6_q;
  logic        serialDataIn_q;
  logic        serialClockIn_q;
  logic [3:0]  capture_q;
  logic [15:0] analogOut_q;
  logic [15:0] analogOe_q;
  logic [15:0] analogChan_q;
  logic [1:0]  twoOut_q;
  logic [1:0]  twoOe_q;

  // Write lands at the edge that completes the access phase
  assign wrEn     = psel && penable && pready_q && pwrite && !pslverr_q;
  // Byte-only registers accept lane 0 alone
  assign byteOnly = (pstrb[3:1] == 3'h0);

  // Address decode, read data and refusal, prepared in the setup cycle
  always_comb begin
    rdData_d = 32'h0;
    mapped_d = 1'b1;
    refuse_d = 1'b0;
    // R4 - whole mode word
    if (hit(paddr, ppf_pkg::PIN_ALTERNATE_MODE_IDX)) begin
      rdData_d = {16'h0, pinAltMode_q};
    // R5 - upper byte view
    end else if (hit(paddr, ppf_pkg::PIN_ALTERNATE_MODE_UPPER_IDX)) begin
      rdData_d = {24'h0, pinAltMode_q[15:8]};
    // R10 - output type word
    end else if (hit(paddr, ppf_pkg::PIN_OUTPUT_TYPE_IDX)) begin
      rdData_d = {16'h0, pinOutType_q};
    end else if (hit(paddr, ppf_pkg::PIN_OUTPUT_TYPE_UPPER_IDX)) begin
      rdData_d = {24'h0, pinOutType_q[15:8]};
    end else if (hit(paddr, ppf_pkg::TIMER_PIN_FUNCTION_SEL_HIGH_IDX)) begin
      rdData_d = {24'h0, timerFuncSel_q};
    end else if (hit(paddr, ppf_pkg::ANALOG_PORT_LATCH_LOW_IDX)) begin
      rdData_d = {24'h0, analogLatch_q[7:0]};
      refuse_d = pwrite && !byteOnly;
    end else if (hit(paddr, ppf_pkg::ANALOG_PORT_LATCH_HIGH_IDX)) begin
      rdData_d = {24'h0, analogLatch_q[15:8]};
      refuse_d = pwrite && !byteOnly;
    end else if (hit(paddr, ppf_pkg::ANALOG_PORT_DIRECTION_LOW_IDX)) begin
      rdData_d = {24'h0, analogDir_q[7:0]};
      refuse_d = pwrite && !byteOnly;
    end else if (hit(paddr, ppf_pkg::ANALOG_PORT_DIRECTION_HIGH_IDX)) begin
      rdData_d = {24'h0, analogDir_q[15:8]};
      refuse_d = pwrite && !byteOnly;
    end else if (hit(paddr, ppf_pkg::TWO_PIN_LATCH_IDX)) begin
      rdData_d = {30'h0, twoPinLatch_q};
    end else if (hit(paddr, ppf_pkg::TWO_PIN_DIRECTION_IDX)) begin
      rdData_d = {30'h0, twoPinDir_q};
    end else begin
      mapped_d = 1'b0;
    end
  end

  // One wait-free access cycle: answer registered in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (psel && !penable) begin
      pready_q  <= 1'b1;
      // R13 - refuse wide writes
      pslverr_q <= !mapped_d || refuse_d;
      prdata_q  <= (mapped_d && !pwrite) ? rdData_d : 32'h0;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinAltMode_q <= ppf_pkg::PIN_ALTERNATE_MODE_RST;
    end else if (wrEn && hit(paddr, ppf_pkg::PIN_ALTERNATE_MODE_IDX)) begin
      // R4 - byte lanes of the whole word
      pinAltMode_q <= {laneMerge(pinAltMode_q[15:8], pwdata[15:8], pstrb[1]),
                       laneMerge(pinAltMode_q[7:0], pwdata[7:0], pstrb[0])} & ppf_pkg::PIN_ALTERNATE_MODE_MASK;
    end else if (wrEn && hit(paddr, ppf_pkg::PIN_ALTERNATE_MODE_UPPER_IDX)) begin
      // R5 - upper byte sits in lane 0
      pinAltMode_q[15:8] <= laneMerge(pinAltMode_q[15:8], pwdata[7:0], pstrb[0])
                            & ppf_pkg::PIN_ALTERNATE_MODE_MASK[15:8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinOutType_q <= ppf_pkg::PIN_OUTPUT_TYPE_RST;
    end else if (wrEn && hit(paddr, ppf_pkg::PIN_OUTPUT_TYPE_IDX)) begin
      // R10 - whole word or either byte lane
      pinOutType_q <= {laneMerge(pinOutType_q[15:8], pwdata[15:8], pstrb[1]),
                       laneMerge(pinOutType_q[7:0], pwdata[7:0], pstrb[0])};
    end else if (wrEn && hit(paddr, ppf_pkg::PIN_OUTPUT_TYPE_UPPER_IDX)) begin
      pinOutType_q[15:8] <= laneMerge(pinOutType_q[15:8], pwdata[7:0], pstrb[0]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timerFuncSel_q <= ppf_pkg::TIMER_FUNC_SEL_RST;
    end else if (wrEn && hit(paddr, ppf_pkg::TIMER_PIN_FUNCTION_SEL_HIGH_IDX)) begin
      timerFuncSel_q <= laneMerge(timerFuncSel_q, pwdata[7:0], pstrb[0]) & ppf_pkg::TIMER_FUNC_SEL_MASK;
    end
  end

  // R11 - analog port latch halves
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      analogLatch_q <= {ppf_pkg::ANALOG_LATCH_RST, ppf_pkg::ANALOG_LATCH_RST};
    end else if (wrEn && hit(paddr, ppf_pkg::ANALOG_PORT_LATCH_LOW_IDX)) begin
      analogLatch_q[7:0] <= pwdata[7:0];
    end else if (wrEn && hit(paddr, ppf_pkg::ANALOG_PORT_LATCH_HIGH_IDX)) begin
      analogLatch_q[15:8] <= pwdata[7:0];
    end
  end

  // R14 - analog port direction halves
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      analogDir_q <= {ppf_pkg::ANALOG_DIRECTION_RST, ppf_pkg::ANALOG_DIRECTION_RST};
    end else if (wrEn && hit(paddr, ppf_pkg::ANALOG_PORT_DIRECTION_LOW_IDX)) begin
      analogDir_q[7:0] <= pwdata[7:0];
    end else if (wrEn && hit(paddr, ppf_pkg::ANALOG_PORT_DIRECTION_HIGH_IDX)) begin
      analogDir_q[15:8] <= pwdata[7:0];
    end
  end

  // R16 - two-pin port latch and direction
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      twoPinLatch_q <= ppf_pkg::TWO_PIN_LATCH_RST;
      twoPinDir_q   <= ppf_pkg::TWO_PIN_DIRECTION_RST;
    end else if (wrEn && hit(paddr, ppf_pkg::TWO_PIN_LATCH_IDX) && pstrb[0]) begin
      twoPinLatch_q <= pwdata[1:0];
    end else if (wrEn && hit(paddr, ppf_pkg::TWO_PIN_DIRECTION_IDX) && pstrb[0]) begin
      twoPinDir_q <= pwdata[1:0];
    end
  end

  // Peripheral side of each pin in alternate mode
  always_comb begin
    altOut   = 16'h0;
    altDrive = 16'h0;
    altOut[ppf_pkg::RT_PIN_LAST:0]   = realtimeOutputPin;
    altDrive[ppf_pkg::RT_PIN_LAST:0] = 6'h3f;
    // R3 - serial data out and clock
    altOut[ppf_pkg::SERIAL_OUT_BIT]     = serialDataOutPin;
    altDrive[ppf_pkg::SERIAL_OUT_BIT]   = 1'b1;
    altOut[ppf_pkg::SERIAL_CLOCK_BIT]   = serialClockOut;
    altDrive[ppf_pkg::SERIAL_CLOCK_BIT] = serialClockOe;
    // R2 - pin nine timer output only when selected; pin eleven always drives
    altOut[ppf_pkg::TIMER_B0_BIT]     = timerOutputB0;
    altDrive[ppf_pkg::TIMER_B0_BIT]   = timerFuncSel_q[ppf_pkg::FSEL_B0_POS];
    altOut[ppf_pkg::TIMER_B1_OUT_BIT]   = timerOutputB1;
    altDrive[ppf_pkg::TIMER_B1_OUT_BIT] = 1'b1;
    // R7 - pin twelve output select
    altOut[ppf_pkg::TIMER_C0_BIT]   = timerOutputC0;
    altDrive[ppf_pkg::TIMER_C0_BIT] = timerFuncSel_q[ppf_pkg::FSEL_C0_POS];
    // R6 - pin thirteen output select
    altOut[ppf_pkg::TIMER_C1_BIT]   = timerOutputC1;
    altDrive[ppf_pkg::TIMER_C1_BIT] = timerFuncSel_q[ppf_pkg::FSEL_C1_POS];
    // R17 - mode bit picks peripheral or port
    srcOut   = (pinAltMode_q & altOut) | (~pinAltMode_q & gpioLatch6);
    srcDrive = (pinAltMode_q & altDrive) | (~pinAltMode_q & ~gpioDir6);
  end

  // R8 - open-drain only ever pulls low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinOut6_q <= 16'h0;
      pinOe6_q  <= 16'h0;
    end else begin
      pinOut6_q <= srcOut & ~pinOutType_q;
      pinOe6_q  <= srcDrive & ~(pinOutType_q & srcOut);
    end
  end

  // Inputs to peripherals read low unless routed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      serialDataIn_q  <= 1'b0;
      serialClockIn_q <= 1'b0;
      capture_q       <= 4'h0;
    end else begin
      // R3 - serial data and clock inputs
      serialDataIn_q  <= pinAltMode_q[ppf_pkg::SERIAL_IN_BIT] & pinIn6[ppf_pkg::SERIAL_IN_BIT];
      serialClockIn_q <= pinAltMode_q[ppf_pkg::SERIAL_CLOCK_BIT] & pinIn6[ppf_pkg::SERIAL_CLOCK_BIT];
      // R2 - capture input on pin nine
      capture_q[0] <= pinAltMode_q[ppf_pkg::TIMER_B0_BIT] & ~timerFuncSel_q[ppf_pkg::FSEL_B0_POS]
                      & pinIn6[ppf_pkg::TIMER_B0_BIT];
      // R1 - capture input on pin ten
      capture_q[1] <= pinAltMode_q[ppf_pkg::TIMER_B1_IN_BIT] & pinIn6[ppf_pkg::TIMER_B1_IN_BIT];
      // R7 - capture input on pin twelve
      capture_q[2] <= pinAltMode_q[ppf_pkg::TIMER_C0_BIT] & ~timerFuncSel_q[ppf_pkg::FSEL_C0_POS]
                      & pinIn6[ppf_pkg::TIMER_C0_BIT];
      // R6 - capture input on pin thirteen
      capture_q[3] <= pinAltMode_q[ppf_pkg::TIMER_C1_BIT] & ~timerFuncSel_q[ppf_pkg::FSEL_C1_POS]
                      & pinIn6[ppf_pkg::TIMER_C1_BIT];
    end
  end

  // Analog channel sees the pin only in input mode, so driven levels never feed the converter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      analogOut_q  <= 16'h0;
      analogOe_q   <= 16'h0;
      analogChan_q <= 16'h0;
      twoOut_q     <= 2'h0;
      twoOe_q      <= 2'h0;
    end else begin
      // R11 - latch drives in output mode
      analogOut_q  <= analogLatch_q;
      // R14 - direction zero enables the driver
      analogOe_q   <= ~analogDir_q;
      analogChan_q <= analogDir_q & analogPortPinIn;
      // R16 - per-pin direction
      twoOut_q     <= twoPinLatch_q;
      twoOe_q      <= ~twoPinDir_q;
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign pinOut6             = pinOut6_q;
  assign pinOe6              = pinOe6_q;
  assign serialDataInPin     = serialDataIn_q;
  assign serialClockIn       = serialClockIn_q;
  assign timerCaptureInputB0 = capture_q[0];
  assign timerCaptureInputB1 = capture_q[1];
  assign timerCaptureInputC0 = capture_q[2];
  assign timerCaptureInputC1 = capture_q[3];
  assign analogPortPinOut    = analogOut_q;
  assign analogPortPinOe     = analogOe_q;
  assign analogInputChannel  = analogChan_q;
  assign twoPinOut           = twoOut_q;
  assign twoPinOe            = twoOe_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  apb_ready_timing_a: assert property (psel && !penable |=> pready && $past(psel)) // R4
    else $error("pready not high in first access cycle");
  mode_word_write_a: assert property (psel && penable && pready && pwrite && !pslverr // R4
      && paddr == {ppf_pkg::PIN_ALTERNATE_MODE_IDX[29:0], 2'h0} && pstrb == 4'h3
      |=> pinAltMode_q == ($past(pwdata[15:0]) & ppf_pkg::PIN_ALTERNATE_MODE_MASK))
    else $error("mode word write not stored");
  upper_byte_view_a: assert property (psel && !penable && !pwrite // R5
      && paddr == {ppf_pkg::PIN_ALTERNATE_MODE_UPPER_IDX[29:0], 2'h0}
      |=> prdata[7:0] == pinAltMode_q[15:8] && prdata[31:8] == 24'h0)
    else $error("upper byte read mismatch");
  analog_wide_refuse_a: assert property (psel && !penable && pwrite && pstrb[1] // R13
      && (paddr == {ppf_pkg::ANALOG_PORT_LATCH_LOW_IDX[29:0], 2'h0}
      || paddr == {ppf_pkg::ANALOG_PORT_LATCH_HIGH_IDX[29:0], 2'h0})
      |=> pslverr ##1 $stable(analogLatch_q))
    else $error("wide analog write not refused");
  open_drain_high_a: assert property (pinOutType_q[0] |=> !(pinOe6[0] && pinOut6[0])) // R8
    else $error("open-drain pin driven high");
  serial_clock_route_a: assert property (pinAltMode_q[8] && !pinOutType_q[8] // R3
      |=> pinOe6[8] == $past(serialClockOe) && pinOut6[8] == $past(serialClockOut))
    else $error("serial clock not routed");
  pin_ten_capture_a: assert property (##1 timerCaptureInputB1 == ($past(pinAltMode_q[10]) && $past(pinIn6[10]))) // R1
    else $error("pin ten capture wrong");
  pin_nine_select_a: assert property (pinAltMode_q[9] && timerFuncSel_q[1] |=> !timerCaptureInputB0) // R2
    else $error("pin nine capture while output selected");
  pin_twelve_out_a: assert property (pinAltMode_q[12] && timerFuncSel_q[4] && !pinOutType_q[12] // R7
      |=> pinOe6[12] && pinOut6[12] == $past(timerOutputC0))
    else $error("pin twelve timer output not driven");
  pin_thirteen_in_a: assert property (pinAltMode_q[13] && !timerFuncSel_q[5] |=> !pinOe6[13]) // R6
    else $error("pin thirteen driven in capture mode");
  analog_dir_drive_a: assert property (##1 analogPortPinOe == ~$past(analogDir_q)) // R14
    else $error("analog direction not applied");
  alt_overrides_a: assert property (pinAltMode_q[3] && !pinOutType_q[3] // R17
      |=> pinOe6[3] && pinOut6[3] == $past(realtimeOutputPin[3]))
    else $error("alternate output not in control");

  cov_wide_refuse: cover property (psel && penable && pready && pslverr);
  cov_open_drain_low: cover property (pinOutType_q[7] && pinOe6[7]);
  cov_timer_out: cover property (pinAltMode_q[9] && timerFuncSel_q[1] ##1 pinOe6[9]);
  cov_analog_out: cover property (analogPortPinOe[0] && analogPortPinOut[0]);

endmodule // ppf_port_pin_function

`default_nettype wire

// ==== verif/ppf_port_pin_function_tb.sv ====
// Self-checking bench for the port pin function block: APB register map and pin routing
`timescale 1ns/100ps
`default_nettype none
module ppf_port_pin_function_tb;
  typedef struct packed {logic wr; logic [31:0] d; logic e;} ppf_note_t;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic [15:0] gpioLatch6, gpioDir6, pinIn6, pinOut6, pinOe6;
  logic [15:0] analogPortPinIn, analogPortPinOut, analogPortPinOe, analogInputChannel;
  logic [5:0]  realtimeOutputPin;
  logic        serialDataOutPin, serialClockOut, serialClockOe, serialDataInPin, serialClockIn;
  logic        timerOutputB0, timerOutputB1, timerOutputC0, timerOutputC1;
  logic        timerCaptureInputB0, timerCaptureInputB1, timerCaptureInputC0, timerCaptureInputC1;
  logic [1:0]  twoPinIn, twoPinOut, twoPinOe;
  ppf_note_t   noteQ[$];
  ppf_note_t   note;
  int          n_mismatch = 0;
  int          total_checks = 0;

  ppf_port_pin_function u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpioLatch6(gpioLatch6), .gpioDir6(gpioDir6), .pinIn6(pinIn6), .pinOut6(pinOut6), .pinOe6(pinOe6),
    .realtimeOutputPin(realtimeOutputPin), .serialDataOutPin(serialDataOutPin), .serialClockOut(serialClockOut),
    .serialClockOe(serialClockOe), .serialDataInPin(serialDataInPin), .serialClockIn(serialClockIn),
    .timerOutputB0(timerOutputB0), .timerOutputB1(timerOutputB1), .timerOutputC0(timerOutputC0),
    .timerOutputC1(timerOutputC1), .timerCaptureInputB0(timerCaptureInputB0),
    .timerCaptureInputB1(timerCaptureInputB1), .timerCaptureInputC0(timerCaptureInputC0),
    .timerCaptureInputC1(timerCaptureInputC1), .analogPortPinIn(analogPortPinIn),
    .analogPortPinOut(analogPortPinOut), .analogPortPinOe(analogPortPinOe), .analogInputChannel(analogInputChannel),
    .twoPinIn(twoPinIn), .twoPinOut(twoPinOut), .twoPinOe(twoPinOe));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD read data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_err(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD error flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD pin value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Word index to byte address; the request stays up until pready is sampled
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd, input logic [3:0] st,
                     input logic [31:0] expd, input logic experr);
    int n;
    noteQ.push_back('{wr: wr, d: expd, e: experr});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[29:0], 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Release the bus, then give registers and pin outputs time to land
  task automatic settle();
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && noteQ.size() > 0) begin
      note = noteQ.pop_front();
      if (!note.wr) cmp_rd(prdata, note.d);
      cmp_err(pslverr, note.e);
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, gpioLatch6, pinIn6, analogPortPinIn, twoPinIn} = '0;
    {realtimeOutputPin, serialDataOutPin, serialClockOut, serialClockOe} = '0;
    {timerOutputB0, timerOutputB1, timerOutputC0, timerOutputC1} = '0;
    gpioDir6 = 16'hffff;
    rst_n = 1'b0;
    void'($urandom(32'h501a));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    gpioDir6 <= 16'h0000;
    gpioLatch6 <= 16'($urandom);
    pinIn6 <= 16'($urandom);
    analogPortPinIn <= 16'($urandom);
    twoPinIn <= 2'($urandom);
    {realtimeOutputPin, serialDataOutPin, serialClockOut, serialClockOe} <= 9'($urandom);
    {timerOutputB0, timerOutputB1, timerOutputC0, timerOutputC1} <= 4'($urandom);
    @(posedge ref_clk);
    apb(0, ppf_pkg::PIN_ALTERNATE_MODE_IDX, 0, 0, 0, 0);
    apb(0, ppf_pkg::PIN_OUTPUT_TYPE_IDX, 0, 0, 0, 0);
    apb(0, ppf_pkg::TIMER_PIN_FUNCTION_SEL_HIGH_IDX, 0, 0, 0, 0);
    apb(0, ppf_pkg::ANALOG_PORT_LATCH_LOW_IDX, 0, 0, 0, 0);
    apb(0, ppf_pkg::ANALOG_PORT_DIRECTION_HIGH_IDX, 0, 0, 32'hff, 0);
    apb(1, 32'h1, 32'hffff, 4'hf, 0, 1);
    apb(0, 32'h1, 0, 0, 0, 1);
    settle();
    cmp_pin(analogPortPinOe, 16'h0000);
    cmp_pin({14'h0, twoPinOe}, 16'h0000);
    cmp_pin(analogInputChannel, analogPortPinIn);
    cmp_pin(pinOut6, gpioLatch6);
    cmp_pin(pinOe6, 16'hffff);
    apb(1, ppf_pkg::PIN_OUTPUT_TYPE_IDX, 32'hffff, 4'h3, 0, 0);
    settle();
    cmp_pin(pinOut6, 16'h0000);
    cmp_pin(pinOe6, ~gpioLatch6);
    apb(1, ppf_pkg::PIN_OUTPUT_TYPE_UPPER_IDX, 32'h00, 4'h1, 0, 0);
    apb(0, ppf_pkg::PIN_OUTPUT_TYPE_IDX, 0, 0, 32'h00ff, 0);
    apb(1, ppf_pkg::PIN_OUTPUT_TYPE_IDX, 32'h0, 4'h3, 0, 0);
    apb(1, ppf_pkg::PIN_ALTERNATE_MODE_IDX, 32'hffff, 4'h3, 0, 0);
    apb(0, ppf_pkg::PIN_ALTERNATE_MODE_UPPER_IDX, 0, 0, 32'h3f, 0);
    apb(1, ppf_pkg::TIMER_PIN_FUNCTION_SEL_HIGH_IDX, 32'hff, 4'h1, 0, 0);
    apb(0, ppf_pkg::TIMER_PIN_FUNCTION_SEL_HIGH_IDX, 0, 0, 32'h32, 0);
    settle();
    cmp_pin(pinOut6 & 16'h3bbf, {2'b00, timerOutputC1, timerOutputC0, timerOutputB1, 1'b0, timerOutputB0,
      serialClockOut, serialDataOutPin, 1'b0, realtimeOutputPin});
    cmp_pin(pinOe6 & 16'h3fff, {4'b0011, 2'b10, 1'b1, serialClockOe, 2'b10, 6'h3f});
    cmp_pin({12'h0, timerCaptureInputB0, timerCaptureInputC0, timerCaptureInputC1, timerCaptureInputB1},
      {15'h0, pinIn6[10]});
    cmp_pin({14'h0, serialDataInPin, serialClockIn}, {14'h0, pinIn6[6], pinIn6[8]});
    apb(1, ppf_pkg::TIMER_PIN_FUNCTION_SEL_HIGH_IDX, 32'h00, 4'h1, 0, 0);
    settle();
    cmp_pin({13'h0, timerCaptureInputB0, timerCaptureInputC0, timerCaptureInputC1},
      {13'h0, pinIn6[9], pinIn6[12], pinIn6[13]});
    cmp_pin(pinOe6 & 16'h3200, 16'h0000);
    apb(1, ppf_pkg::PIN_ALTERNATE_MODE_UPPER_IDX, 32'h00, 4'h1, 0, 0);
    apb(0, ppf_pkg::PIN_ALTERNATE_MODE_IDX, 0, 0, 32'h00ff, 0);
    settle();
    cmp_pin({12'h0, timerCaptureInputB0, timerCaptureInputB1, timerCaptureInputC0, timerCaptureInputC1},
      16'h0000);
    cmp_pin(pinOut6 & 16'hff00, gpioLatch6 & 16'hff00);
    apb(1, ppf_pkg::ANALOG_PORT_LATCH_LOW_IDX, 32'ha5, 4'h1, 0, 0);
    apb(1, ppf_pkg::ANALOG_PORT_LATCH_LOW_IDX, 32'hffff, 4'h3, 0, 1);
    apb(1, ppf_pkg::ANALOG_PORT_LATCH_HIGH_IDX, 32'hffff, 4'h3, 0, 1);
    apb(1, ppf_pkg::ANALOG_PORT_LATCH_HIGH_IDX, 32'h3c, 4'h1, 0, 0);
    apb(0, ppf_pkg::ANALOG_PORT_LATCH_HIGH_IDX, 0, 0, 32'h3c, 0);
    apb(1, ppf_pkg::ANALOG_PORT_DIRECTION_LOW_IDX, 32'h00, 4'h1, 0, 0);
    apb(1, ppf_pkg::ANALOG_PORT_DIRECTION_HIGH_IDX, 32'h0000, 4'h3, 0, 1);
    apb(1, ppf_pkg::TWO_PIN_LATCH_IDX, 32'h2, 4'h1, 0, 0);
    apb(1, ppf_pkg::TWO_PIN_DIRECTION_IDX, 32'h1, 4'h1, 0, 0);
    apb(0, ppf_pkg::TWO_PIN_DIRECTION_IDX, 0, 0, 32'h1, 0);
    settle();
    cmp_pin(analogPortPinOut, 16'h3ca5);
    cmp_pin(analogPortPinOe, 16'h00ff);
    cmp_pin(analogInputChannel, analogPortPinIn & 16'hff00);
    cmp_pin({12'h0, twoPinOut, twoPinOe}, 16'h000a);
    // Second reset in mid-run: registers return to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(0, ppf_pkg::ANALOG_PORT_LATCH_HIGH_IDX, 0, 0, 32'h00, 0);
    apb(0, ppf_pkg::ANALOG_PORT_DIRECTION_LOW_IDX, 0, 0, 32'hff, 0);
    apb(0, ppf_pkg::TWO_PIN_DIRECTION_IDX, 0, 0, 32'h3, 0);
    settle();
    cmp_pin({12'h0, twoPinOut, twoPinOe}, 16'h0000);
    cmp_pin(analogPortPinOe, 16'h0000);
    tally_and_finish();
  end
endmodule // ppf_port_pin_function_tb
`default_nettype wire
